// ### fan_monitor_pkg.sv
// Package with register map, field positions and reset values of the fan monitor register bank
package fan_monitor_pkg;
   // Register indices; each register is one word, so its byte address is the index times four
   localparam logic [7:0] pwm_one_ceiling_off = 8'h38;
   localparam logic [7:0] pwm_two_ceiling_off = 8'h39;
   localparam logic [7:0] pwm_three_ceiling_off = 8'h3A;
   localparam logic [7:0] main_control_off = 8'h40;
   localparam logic [7:0] limit_flags_first_off = 8'h41;
   localparam logic [7:0] limit_flags_second_off = 8'h42;
   // Register index to byte address scale
   localparam int addr_scale_shift = 2;

   localparam logic [7:0] ceiling_reset = 8'hFF;
   localparam logic [7:0] main_control_reset = 8'h01;
   localparam logic [7:0] flags_reset = 8'h00;
   // Power-up defaults used while monitoring is not running
   localparam logic [7:0] default_ceiling = 8'hFF;

   // Main control field positions, then summary_bit, bit 7 of the first limit flags register
   localparam int run_bit = 0;
   localparam int lock_bit = 1;
   localparam int ready_bit = 2;
   localparam int max_force_bit = 3;
   localparam int power_calc_bit = 4;
   localparam int spinup_bit = 5;
   localparam int timeout_bit = 6;
   localparam int supply_scale_bit = 7;
   localparam int summary_bit = 7;
   // Main control bits that stay writable under lock
   localparam logic [7:0] unlockable_mask = 8'h28;

   // Power-up settle time before ready
   localparam int settle_time_us = 10;
   localparam int clk_mhz = 50;
   localparam int settle_cycles = settle_time_us * clk_mhz;

   typedef struct packed {
      logic monitor_run;
      logic fans_max_force;
      logic power_calc_flag;
      logic spinup_select;
      logic bus_timeout_ctl;
      logic supply_is_five;
      logic locked;
      logic ready;
   } control_out_t;

   typedef struct packed {
      logic [7:0] one;
      logic [7:0] two;
      logic [7:0] three;
   } ceilings_t;
endpackage

// ### fan_monitor_config_lock_status.sv
// AHB-Lite register bank for the fan monitor: duty ceilings, main control with lock, limit status flags
`timescale 1ns/1ps
module fan_monitor_config_lock_status
   import fan_monitor_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Live out-of-limit conditions from the measurement engines
   input wire logic [6:0] limit_cond,
   // Live conditions of the second status group
   input wire logic [7:0] second_cond,
   output control_out_t ctrl,
   output ceilings_t active_ceiling
);
   logic [7:0] ceil_one;
   logic [7:0] ceil_two;
   logic [7:0] ceil_three;
   logic [7:0] control;
   logic [7:0] flags_first;
   logic [7:0] flags_second;
   logic [15:0] settle_cnt;
   logic ready;
   logic wr_pend;
   logic [7:0] wr_addr;

   // Address phase decode
   wire addr_take = hsel && hready && htrans[1];
   // Word registers: the index sits above the two byte lane bits
   wire [7:0] a_off = 8'(haddr >> addr_scale_shift);
   wire rd_take = addr_take && !hwrite;
   wire wr_take = addr_take && hwrite;
   wire locked = control[lock_bit];
   wire [7:0] wbyte = hwdata[7:0];
   wire in_range = ((haddr >> (addr_scale_shift + 8)) == 32'h00000000) && (haddr[1:0] == 2'b00);
   wire hit_one = in_range && (a_off == pwm_one_ceiling_off);
   wire hit_two = in_range && (a_off == pwm_two_ceiling_off);
   wire hit_three = in_range && (a_off == pwm_three_ceiling_off);
   wire hit_ctrl = in_range && (a_off == main_control_off);
   wire hit_first = in_range && (a_off == limit_flags_first_off);
   wire hit_second = in_range && (a_off == limit_flags_second_off);
   // Writes land in the data phase, when hwdata is valid
   wire w_one = wr_pend && (wr_addr == pwm_one_ceiling_off) && !locked;
   wire w_two = wr_pend && (wr_addr == pwm_two_ceiling_off) && !locked;
   wire w_three = wr_pend && (wr_addr == pwm_three_ceiling_off) && !locked;
   wire w_ctrl = wr_pend && (wr_addr == main_control_off);
   // Under lock only full-speed and spin-up select pass; ready is never writable
   wire [7:0] wmask = locked ? unlockable_mask : ~(8'h01 << ready_bit);
   // Lock may be set once but never cleared by software
   wire [7:0] ctrl_w = (control & ~wmask) | (wbyte & wmask) | (control & (8'h01 << lock_bit));
   wire [7:0] ctrl_view = {control[7:3], ready, control[1:0]};
   // Read clears only flags whose cause has gone; a live cause keeps it set
   wire [6:0] next_first = rd_take && hit_first ? limit_cond : (flags_first[6:0] | limit_cond);
   wire [7:0] next_second = rd_take && hit_second ? second_cond : (flags_second | second_cond);
   wire [7:0] first_view = {|flags_second, flags_first[6:0]};
   wire [7:0] rd_sel = hit_one ? ceil_one :
                       hit_two ? ceil_two :
                       hit_three ? ceil_three :
                       hit_ctrl ? ctrl_view :
                       hit_first ? first_view :
                       hit_second ? flags_second : 8'h00;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hrdata <= 32'h00000000;
      end
      else
      begin
         wr_pend <= wr_take && in_range;
         wr_addr <= a_off;
         if (rd_take)
            hrdata <= {24'h000000, rd_sel};
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ceil_one <= ceiling_reset;
         ceil_two <= ceiling_reset;
         ceil_three <= ceiling_reset;
         control <= main_control_reset;
      end
      else
      begin
         if (w_one)
            ceil_one <= wbyte;
         if (w_two)
            ceil_two <= wbyte;
         if (w_three)
            ceil_three <= wbyte;
         if (w_ctrl)
            control <= ctrl_w;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         flags_first <= flags_reset;
         flags_second <= flags_reset;
      end
      else
      begin
         flags_first <= {1'b0, next_first};
         flags_second <= next_second;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         settle_cnt <= 16'h0000;
         ready <= 1'b0;
      end
      else if (settle_cnt == 16'(settle_cycles - 1))
         ready <= 1'b1;
      else
         settle_cnt <= settle_cnt + 16'h0001;
   end

   // Outputs registered; ceilings fall back to defaults while stopped
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl <= '0;
         active_ceiling <= {default_ceiling, default_ceiling, default_ceiling};
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         ctrl.monitor_run <= control[run_bit];
         ctrl.fans_max_force <= control[max_force_bit];
         ctrl.power_calc_flag <= control[power_calc_bit];
         ctrl.spinup_select <= control[spinup_bit];
         ctrl.bus_timeout_ctl <= control[timeout_bit];
         ctrl.supply_is_five <= control[supply_scale_bit];
         ctrl.locked <= control[lock_bit];
         ctrl.ready <= ready;
         // Stored values stay untouched; only the selection changes
         if (control[run_bit])
            active_ceiling <= {ceil_one, ceil_two, ceil_three};
         else
            active_ceiling <= {default_ceiling, default_ceiling, default_ceiling};
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   lock_holds_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      $past(control[lock_bit]) |-> control[lock_bit])
      else $error("lock bit cleared");

   ceil_locked_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      $past(locked) |-> $stable(ceil_one) && $stable(ceil_two) && $stable(ceil_three))
      else $error("ceiling changed under lock");

   run_frozen_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      $past(locked) |-> $stable(control[run_bit]))
      else $error("run changed under lock");

   lockable_frozen_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      $past(locked) |-> $stable(control[7:6]) && $stable(control[4]))
      else $error("lockable bit changed");

   force_writable_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      w_ctrl |=> control[max_force_bit] == $past(wbyte[max_force_bit]))
      else $error("full speed not written");

   spin_writable_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      w_ctrl |=> control[spinup_bit] == $past(wbyte[spinup_bit]))
      else $error("spin-up not written");

   flag_sticky_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      limit_cond[0] |=> flags_first[0])
      else $error("live condition not flagged");

   summary_read_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      rd_take && hit_first |=> hrdata[summary_bit] == $past(|flags_second))
      else $error("summary bit read wrong");

   ceil_select_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !control[run_bit] |=> active_ceiling.one == default_ceiling)
      else $error("default not used");

   ready_time_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      settle_cnt < 16'(settle_cycles - 1) |-> !ready)
      else $error("ready early");

   ceil_one_write_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      w_one |=> ceil_one == $past(wbyte))
      else $error("first ceiling not written");

   ceil_two_write_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      w_two |=> ceil_two == $past(wbyte))
      else $error("second ceiling not written");

   ceil_three_write_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      w_three |=> ceil_three == $past(wbyte))
      else $error("third ceiling not written");

   ceil_one_hold_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !w_one |=> $stable(ceil_one))
      else $error("first ceiling changed unwritten");

   ceil_two_hold_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !w_two |=> $stable(ceil_two))
      else $error("second ceiling changed unwritten");

   ceil_three_hold_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !w_three |=> $stable(ceil_three))
      else $error("third ceiling changed unwritten");

   run_one_select_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      control[run_bit] |=> active_ceiling.one == $past(ceil_one))
      else $error("first programmed ceiling not used");

   run_two_select_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      control[run_bit] |=> active_ceiling.two == $past(ceil_two))
      else $error("second programmed ceiling not used");

   run_three_select_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      control[run_bit] |=> active_ceiling.three == $past(ceil_three))
      else $error("third programmed ceiling not used");

   lock_set_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      w_ctrl && wbyte[lock_bit] |=> control[lock_bit])
      else $error("lock not set by write");

   ready_holds_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      $past(ready) |-> ready)
      else $error("ready dropped");

   ready_late_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      settle_cnt == 16'(settle_cycles - 1) |=> ready)
      else $error("ready late");

   ready_view_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      rd_take && hit_ctrl |=> hrdata[ready_bit] == $past(ready))
      else $error("ready bit read wrong");

   run_out_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      $past(hresetn) |-> ctrl.monitor_run == $past(control[run_bit]))
      else $error("run output wrong");

   force_out_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      $past(hresetn) |-> ctrl.fans_max_force == $past(control[max_force_bit]))
      else $error("full speed output wrong");

   power_out_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      $past(hresetn) |-> ctrl.power_calc_flag == $past(control[power_calc_bit]))
      else $error("power flag output wrong");

   spin_out_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      $past(hresetn) |-> ctrl.spinup_select == $past(control[spinup_bit]))
      else $error("spin-up output wrong");

   timeout_out_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      $past(hresetn) |-> ctrl.bus_timeout_ctl == $past(control[timeout_bit]))
      else $error("timeout output wrong");

   supply_out_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      $past(hresetn) |-> ctrl.supply_is_five == $past(control[supply_scale_bit]))
      else $error("supply scale output wrong");

   lock_out_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      $past(hresetn) |-> ctrl.locked == $past(control[lock_bit]))
      else $error("lock output wrong");

   volt_flags_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      $past(hresetn) |-> (flags_first[2:0] & $past(limit_cond[2:0])) == $past(limit_cond[2:0]))
      else $error("voltage flag missed");

   timer_flag_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      $past(hresetn) |-> flags_first[3] || !$past(limit_cond[3]))
      else $error("five volt or timer flag missed");

   temp_flags_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      $past(hresetn) |-> (flags_first[6:4] & $past(limit_cond[6:4])) == $past(limit_cond[6:4]))
      else $error("temperature flag missed");

   first_clear_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      rd_take && hit_first |=> flags_first[6:0] == $past(limit_cond))
      else $error("first status not cleared on read");

   first_keep_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !(rd_take && hit_first) |=> (flags_first[6:0] & $past(flags_first[6:0])) == $past(flags_first[6:0]))
      else $error("first status lost without read");

   first_read_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      rd_take && hit_first |=> hrdata[6:0] == $past(flags_first[6:0]))
      else $error("first status read wrong");

   second_set_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      $past(hresetn) |-> (flags_second & $past(second_cond)) == $past(second_cond))
      else $error("second status flag missed");

   second_clear_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      rd_take && hit_second |=> flags_second == $past(second_cond))
      else $error("second status not cleared on read");

   run_write_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      w_ctrl && !locked |=> control[run_bit] == $past(wbyte[run_bit]))
      else $error("run not written");

   supply_write_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      w_ctrl && !locked |=> control[supply_scale_bit] == $past(wbyte[supply_scale_bit]))
      else $error("supply scale not written");
endmodule

// ### fan_monitor_host.sv
// Bus host model issuing single-word transfers to the register bank
`timescale 1ns/1ps
module fan_monitor_host
   import fan_monitor_pkg::*;
(
   input wire logic hclk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   initial
   begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   // Address held until accepted, then data held until the slave is ready again
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      // Word registers: byte address is the index times four
      haddr <= 32'(a) << addr_scale_shift;
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wr ? {24'h0, d} : ~hwdata;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
   endtask
endmodule

// ### fan_monitor_config_lock_status_tb.sv
// Self-checking bench for the fan monitor register bank
`timescale 1ns/1ps
module fan_monitor_config_lock_status_tb
   import fan_monitor_pkg::*;
;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd, lfsr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [6:0] limit_cond;
   logic [7:0] second_cond, v;
   logic [7:0] lim [3];
   control_out_t ctrl, exp_c;
   ceilings_t active_ceiling;
   int err_total = 0;
   int cmp_count = 0;
   int cyc = 0;
   fan_monitor_config_lock_status i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .limit_cond(limit_cond), .second_cond(second_cond), .ctrl(ctrl),
      .active_ceiling(active_ceiling));
   fan_monitor_host i_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   function automatic logic [31:0] lfsr_step(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_host.xfer(1'b1, a, d, rd);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      i_host.xfer(1'b0, a, 8'h00, rd);
      check(rd, {24'h0, e});
      check({31'h0, hresp}, 32'h0);
   endtask
   task automatic complete_run;
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end
   // Whole run needs about 700 cycles
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         err_total++;
         complete_run();
      end
   end
   initial
   begin
      hresetn = 1'b0;
      limit_cond = 7'h0;
      second_cond = 8'h0;
      lfsr = 32'hDC37EB18;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 3; i++)
         rd_chk(pwm_one_ceiling_off + 8'(i), ceiling_reset);
      rd_chk(main_control_off, main_control_reset);
      rd_chk(limit_flags_first_off, flags_reset);
      rd_chk(8'h50, 8'h00);
      check(active_ceiling, {3{ceiling_reset}});
      $display("test reset values done");
      // Limits go in while stopped, run is set afterwards
      wr(main_control_off, 8'h00);
      for (int i = 0; i < 3; i++)
      begin
         lfsr = lfsr_step(lfsr);
         lim[i] = lfsr[7:0];
         wr(pwm_one_ceiling_off + 8'(i), lim[i]);
      end
      repeat (3) @(negedge hclk);
      check(active_ceiling, {3{default_ceiling}});
      for (int i = 0; i < 3; i++)
         rd_chk(pwm_one_ceiling_off + 8'(i), lim[i]);
      wr(main_control_off, 8'h01);
      repeat (3) @(negedge hclk);
      check(active_ceiling, {lim[0], lim[1], lim[2]});
      $display("test ceilings done");
      repeat (settle_cycles) @(posedge hclk);
      for (int i = 0; i < 5; i++)
      begin
         lfsr = lfsr_step(lfsr);
         v = (i == 0) ? 8'hF9 : (lfsr[7:0] & 8'hFD);
         wr(main_control_off, v);
         rd_chk(main_control_off, (v & 8'hFB) | 8'h04);
         exp_c = {v[0], v[3], v[4], v[5], v[6], v[7], 1'b0, 1'b1};
         check(ctrl, exp_c);
      end
      wr(main_control_off, 8'h01);
      $display("test control fields done");
      for (int i = 0; i < 3; i++)
      begin
         lfsr = lfsr_step(lfsr);
         v = {1'b0, lfsr[6:0]};
         limit_cond <= v[6:0];
         @(posedge hclk);
         rd_chk(limit_flags_first_off, v);
         rd_chk(limit_flags_first_off, v);
         limit_cond <= 7'h0;
         rd_chk(limit_flags_first_off, v);
         rd_chk(limit_flags_first_off, 8'h00);
      end
      lfsr = lfsr_step(lfsr);
      v = lfsr[7:0] | 8'h01;
      second_cond <= v;
      @(posedge hclk);
      second_cond <= 8'h00;
      rd_chk(limit_flags_first_off, 8'h80);
      rd_chk(limit_flags_second_off, v);
      rd_chk(limit_flags_first_off, 8'h00);
      $display("test status flags done");
      wr(main_control_off, 8'h03);
      for (int i = 0; i < 3; i++)
         wr(pwm_one_ceiling_off + 8'(i), ~lim[i]);
      for (int i = 0; i < 3; i++)
         rd_chk(pwm_one_ceiling_off + 8'(i), lim[i]);
      wr(main_control_off, 8'hF8);
      rd_chk(main_control_off, 8'h2F);
      wr(main_control_off, 8'h00);
      rd_chk(main_control_off, 8'h07);
      check(ctrl.locked, 1'b1);
      $display("test lock done");
      // Only a reset may release the lock
      hresetn <= 1'b0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      rd_chk(main_control_off, main_control_reset);
      rd_chk(pwm_one_ceiling_off, ceiling_reset);
      check(ctrl, 8'h80);
      $display("test reset releases lock done");
      complete_run();
   end
endmodule
